// File: core/llm_cfg.svh
`ifndef LLM_CFG_SVH
`define LLM_CFG_SVH

// register offsets on the management port
`define LLM_ADDR_W 5
`define LLM_OFF_SETUP 5'h16
`define LLM_OFF_RES_HIGH 5'h17
`define LLM_OFF_RES_LOW 5'h18
`define LLM_OFF_VEND_CTRL 5'h19

// reset values
`define LLM_SETUP_RST 16'h7F00
`define LLM_RES_RST 16'h0000
`define LLM_VEND_RST 16'h0000
`define LLM_VEND_MASK 16'h077F

// setup field positions
`define LLM_F_START_SEL 7
`define LLM_F_STOP_SEL 6
`define LLM_F_DIV_HI 5
`define LLM_F_DIV_LO 4
`define LLM_F_CLK_SEL 2
`define LLM_F_EN 1
`define LLM_F_CH_SEL 0

// result high field positions
`define LLM_F_START_HI 15
`define LLM_F_START_LO 12
`define LLM_F_STOP_HI 11
`define LLM_F_STOP_LO 8
`define LLM_F_READY 4

// counter geometry
`define LLM_CNT_W 20
`define LLM_CNT_LOW_W 16
`define LLM_DIV_CNT_W 3

`endif

// File: core/llm_pkg.sv
package llm_pkg;
   typedef enum logic [1:0] {
      LLM_ST_IDLE,
      LLM_ST_ARMED,
      LLM_ST_COUNT,
      LLM_ST_DONE
   } llm_state_t;

   typedef logic [1:0] llm_div_t;
endpackage : llm_pkg

// File: core/llm_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "llm_cfg.svh"

module llm_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire llm_pkg::llm_div_t div_i,
   output logic tick_o
);
   import llm_pkg::*;

   logic [`LLM_DIV_CNT_W-1:0] cnt_reg;
   logic [`LLM_DIV_CNT_W-1:0] mask;

   // divide by 1, 2, 4 or 8
   always_comb begin
      case (div_i)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         default: mask = 3'h7;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 3'h0;
      end else if (tick_i) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= tick_i && ((cnt_reg & mask) == mask);
      end
   end

   chk_div_by_one: assert property (@(posedge clk_i) disable iff (rst_i)
      (div_i == 2'h0 && tick_i) |=> tick_o)
      else $error("undivided tick lost");
endmodule : llm_div

`default_nettype wire

// File: core/llm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "llm_cfg.svh"

module llm_top #(
   parameter int CNT_W = `LLM_CNT_W
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic [`LLM_ADDR_W-1:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic REG_RD_I,
   output logic [15:0] REG_RDATA_O,
   input wire logic REF_TICK_I,
   input wire logic BYTE_TICK_A_I,
   input wire logic BYTE_TICK_B_I,
   input wire logic [7:0] COMMA_LOW_SPEED_TX_I,
   input wire logic [3:0] COMMA_HIGH_SPEED_RX_I,
   input wire logic [7:0] COMMA_LOW_SPEED_RX_I,
   input wire logic [3:0] COMMA_HIGH_SPEED_TX_I,
   output logic MEAS_DONE_O
);
   import llm_pkg::*;

   if (CNT_W != 20) begin : g_cnt_w_check
      $error("counter width must be 20");
   end

   logic [15:0] setup_reg;
   logic [15:0] vend_reg;
   llm_state_t state_reg;
   llm_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [3:0] start_flags_reg;
   logic [3:0] stop_flags_reg;
   logic ready_reg;

   logic en;
   logic ch_b;
   logic clk_sel;
   logic start_sel;
   logic stop_sel;
   logic div_tick;
   logic byte_tick;
   logic tick;
   logic [3:0] start_vec;
   logic [3:0] stop_vec;
   logic start_hit;
   logic stop_hit;
   logic rd_low;
   logic rd_high;
   logic clr;
   logic [CNT_W-1:0] cnt_max;
   logic [CNT_W-1:0] cnt_vis;

   assign en = setup_reg[`LLM_F_EN];
   assign ch_b = setup_reg[`LLM_F_CH_SEL];
   assign clk_sel = setup_reg[`LLM_F_CLK_SEL];
   assign start_sel = setup_reg[`LLM_F_START_SEL];
   assign stop_sel = setup_reg[`LLM_F_STOP_SEL];
   assign cnt_max = {CNT_W{1'b1}};

   llm_div u_div (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .tick_i(REF_TICK_I),
      .div_i(setup_reg[`LLM_F_DIV_HI:`LLM_F_DIV_LO]),
      .tick_o(div_tick)
   );

   // count clock and channel choice
   assign byte_tick = ch_b ? BYTE_TICK_B_I : BYTE_TICK_A_I;
   assign tick = clk_sel ? byte_tick : div_tick;

   // comma position vectors of the measured channel
   always_comb begin
      if (start_sel) begin
         start_vec = {2'h0, (ch_b ? COMMA_HIGH_SPEED_RX_I[3:2]
                                  : COMMA_HIGH_SPEED_RX_I[1:0])};
      end else begin
         start_vec = ch_b ? COMMA_LOW_SPEED_TX_I[7:4] : COMMA_LOW_SPEED_TX_I[3:0];
      end
      if (stop_sel) begin
         stop_vec = {2'h0, (ch_b ? COMMA_HIGH_SPEED_TX_I[3:2]
                                 : COMMA_HIGH_SPEED_TX_I[1:0])};
      end else begin
         stop_vec = ch_b ? COMMA_LOW_SPEED_RX_I[7:4] : COMMA_LOW_SPEED_RX_I[3:0];
      end
   end

   assign start_hit = en && (state_reg == LLM_ST_ARMED) && (|start_vec);
   assign stop_hit = en && (state_reg == LLM_ST_COUNT) && (|stop_vec);
   assign rd_low = REG_RD_I && (REG_ADDR_I == `LLM_OFF_RES_LOW);
   assign rd_high = REG_RD_I && (REG_ADDR_I == `LLM_OFF_RES_HIGH);
   // events in the clearing cycle win over the clear
   assign clr = rd_low && !stop_hit && !start_hit;

   // setup and vendor control registers
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         setup_reg <= `LLM_SETUP_RST;
      end else if (REG_WR_I && REG_ADDR_I == `LLM_OFF_SETUP) begin
         setup_reg <= REG_WDATA_I;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         vend_reg <= `LLM_VEND_RST;
      end else if (REG_WR_I && REG_ADDR_I == `LLM_OFF_VEND_CTRL) begin
         vend_reg <= REG_WDATA_I & `LLM_VEND_MASK;
      end
   end

   // measurement sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LLM_ST_IDLE: begin
            // unread results stand until the low read
            if (ready_reg && !clr) begin
               state_next = LLM_ST_DONE;
            end else begin
               state_next = LLM_ST_ARMED;
            end
         end
         LLM_ST_ARMED: begin
            if (start_hit) begin
               state_next = LLM_ST_COUNT;
            end
         end
         LLM_ST_COUNT: begin
            if (stop_hit) begin
               state_next = LLM_ST_DONE;
            end else if (clr) begin
               state_next = LLM_ST_ARMED;
            end
         end
         LLM_ST_DONE: begin
            if (clr) begin
               state_next = LLM_ST_ARMED;
            end
         end
         default: begin
            state_next = LLM_ST_IDLE;
         end
      endcase
      if (!en) begin
         state_next = LLM_ST_IDLE;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         state_reg <= LLM_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // latency counter
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         cnt_reg <= '0;
      end else if (start_hit) begin
         cnt_reg <= '0;
      end else if (clr) begin
         cnt_reg <= '0;
      end else if (en && state_reg == LLM_ST_COUNT && tick && !stop_hit) begin
         if (cnt_reg != cnt_max) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
         end
      end
   end

   // comma flags and ready
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         start_flags_reg <= 4'h0;
      end else if (start_hit) begin
         start_flags_reg <= start_vec;
      end else if (clr) begin
         start_flags_reg <= 4'h0;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         stop_flags_reg <= 4'h0;
      end else if (stop_hit) begin
         stop_flags_reg <= stop_vec;
      end else if (clr) begin
         stop_flags_reg <= 4'h0;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         ready_reg <= 1'b0;
      end else if (stop_hit) begin
         ready_reg <= 1'b1;
      end else if (clr) begin
         ready_reg <= 1'b0;
      end
   end

   // count shows zero until the stop comma arrived
   assign cnt_vis = ready_reg ? cnt_reg : '0;

   // read data, registered
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         REG_RDATA_O <= `LLM_RES_RST;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            `LLM_OFF_SETUP: begin
               REG_RDATA_O <= setup_reg;
            end
            `LLM_OFF_RES_HIGH: begin
               REG_RDATA_O <= {start_flags_reg, stop_flags_reg, 3'h0, ready_reg,
                               cnt_vis[CNT_W-1:`LLM_CNT_LOW_W]};
            end
            `LLM_OFF_RES_LOW: begin
               REG_RDATA_O <= cnt_vis[`LLM_CNT_LOW_W-1:0];
            end
            `LLM_OFF_VEND_CTRL: begin
               REG_RDATA_O <= vend_reg;
            end
            default: begin
               REG_RDATA_O <= 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         MEAS_DONE_O <= 1'b0;
      end else begin
         MEAS_DONE_O <= ready_reg || stop_hit;
      end
   end

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);

   chk_disable_idle: assert property (!en |=> state_reg == LLM_ST_IDLE)
      else $error("measurement running while disabled");

   chk_start_counts: assert property (start_hit |=> state_reg == LLM_ST_COUNT
      && cnt_reg == '0 && start_flags_reg == $past(start_vec))
      else $error("start comma did not begin count");

   chk_count_step: assert property ((en && state_reg == LLM_ST_COUNT && tick && !stop_hit
      && !clr && cnt_reg != cnt_max) |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("count did not advance on tick");

   chk_count_hold: assert property ((state_reg == LLM_ST_COUNT && !tick && !clr)
      |=> cnt_reg == $past(cnt_reg))
      else $error("count moved without tick");

   chk_count_sat: assert property ((cnt_reg == cnt_max && !clr && !start_hit)
      |=> cnt_reg == cnt_max)
      else $error("counter wrapped");

   chk_stop_ready: assert property (stop_hit |=> ready_reg
      && stop_flags_reg == $past(stop_vec) && state_reg != LLM_ST_COUNT ##1 MEAS_DONE_O)
      else $error("stop comma did not raise ready");

   chk_zero_early: assert property ((rd_low && !ready_reg) |=> REG_RDATA_O == 16'h0000)
      else $error("count visible before stop");

   chk_high_nibble: assert property ((rd_high && ready_reg)
      |=> REG_RDATA_O[3:0] == $past(cnt_reg[19:16]) && REG_RDATA_O[4])
      else $error("high result word wrong");

   chk_read_clears: assert property (clr |=> cnt_reg == '0 && !ready_reg
      && start_flags_reg == 4'h0 && stop_flags_reg == 4'h0)
      else $error("low read did not clear result");

   chk_done_output: assert property (ready_reg |=> MEAS_DONE_O)
      else $error("done output not following ready");

   chk_low_word: assert property ((rd_low && ready_reg)
      |=> REG_RDATA_O == $past(cnt_reg[15:0]))
      else $error("low result word wrong");
endmodule : llm_top

`default_nettype wire

// File: sim/llm_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "llm_cfg.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %s expected %h seen %h", n, e, g); end end

module llm_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [`LLM_ADDR_W-1:0] addr = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [2:0] ticks = 3'h0;
   logic [7:0] lo_tx = 8'h00;
   logic [3:0] hi_rx = 4'h0;
   logic [7:0] lo_rx = 8'h00;
   logic [3:0] hi_tx = 4'h0;
   logic done;
   logic [15:0] v;
   int fail_count = 0;
   int num_checks = 0;

   always #12.5 clk = ~clk;

   llm_top uut (.CLK_SYS_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REF_TICK_I(ticks[0]),
      .BYTE_TICK_A_I(ticks[1]), .BYTE_TICK_B_I(ticks[2]), .COMMA_LOW_SPEED_TX_I(lo_tx),
      .COMMA_HIGH_SPEED_RX_I(hi_rx), .COMMA_LOW_SPEED_RX_I(lo_rx),
      .COMMA_HIGH_SPEED_TX_I(hi_tx),
      .MEAS_DONE_O(done));

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
   endtask : wr_reg

   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      addr = a;
      rd = 1'b1;
      step(1);
      d = rdata;
      rd = 1'b0;
      step(1);
   endtask : rd_reg

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // register defaults, access kinds, and no activity while disabled
   task automatic chk_reset;
      rd_reg(`LLM_OFF_SETUP, v);
      `CHK("setup_rst", `LLM_SETUP_RST, v)
      rd_reg(`LLM_OFF_RES_HIGH, v);
      `CHK("high_rst", `LLM_RES_RST, v)
      rd_reg(`LLM_OFF_RES_LOW, v);
      `CHK("low_rst", `LLM_RES_RST, v)
      wr_reg(`LLM_OFF_VEND_CTRL, 16'hFFFF);
      rd_reg(`LLM_OFF_VEND_CTRL, v);
      `CHK("vend_mask", `LLM_VEND_MASK, v)
      rd_reg(5'h05, v);
      `CHK("unmapped", 16'h0000, v)
      wr_reg(`LLM_OFF_RES_HIGH, 16'hFFFF);
      lo_tx = 8'hFF;
      hi_rx = 4'hF;
      ticks = 3'h7;
      step(2);
      lo_rx = 8'hFF;
      hi_tx = 4'hF;
      step(2);
      lo_tx = 8'h00;
      hi_rx = 4'h0;
      lo_rx = 8'h00;
      hi_tx = 4'h0;
      ticks = 3'h0;
      step(3);
      `CHK("done_off", 1'b0, done)
      rd_reg(`LLM_OFF_RES_HIGH, v);
      `CHK("high_off", 16'h0000, v)
   endtask : chk_reset

   // one measurement; a zero stop pattern reads the result early
   task automatic meas(input logic [15:0] setup, input logic [7:0] st_lo,
      input logic [3:0] st_hi, input logic [7:0] sp_lo, input logic [3:0] sp_hi,
      input logic [2:0] mask, input int n, input logic [15:0] exp_hi,
      input logic [15:0] exp_lo);
      int k;
      wr_reg(`LLM_OFF_SETUP, setup);
      step(3);
      lo_tx = st_lo;
      hi_rx = st_hi;
      step(1);
      lo_tx = 8'h00;
      hi_rx = 4'h0;
      ticks = mask;
      step(n);
      ticks = ~mask;
      step(4);
      ticks = 3'h0;
      step(2);
      if (sp_lo != 8'h00 || sp_hi != 4'h0) begin
         lo_rx = sp_lo;
         hi_tx = sp_hi;
         step(1);
         lo_rx = 8'h00;
         hi_tx = 4'h0;
         k = 0;
         while (done !== 1'b1 && k < 20) begin
            step(1);
            k++;
         end
         `CHK("done", 1'b1, done)
         if (done !== 1'b1) summarize();
      end else begin
         `CHK("done_early", 1'b0, done)
      end
      rd_reg(`LLM_OFF_RES_HIGH, v);
      `CHK("result_high", exp_hi, v)
      rd_reg(`LLM_OFF_RES_LOW, v);
      `CHK("result_low", exp_lo, v)
      rd_reg(`LLM_OFF_RES_HIGH, v);
      `CHK("high_cleared", 16'h0000, v)
      rd_reg(`LLM_OFF_RES_LOW, v);
      `CHK("low_cleared", 16'h0000, v)
      `CHK("done_cleared", 1'b0, done)
      wr_reg(`LLM_OFF_SETUP, 16'h0000);
   endtask : meas

   initial begin
      int d;
      step(16);
      rst = 1'b0;
      chk_reset();
      meas(16'h0002, 8'hF1, 4'hF, 8'h34, 4'hF, 3'b001, 5, 16'h1410, 16'h0005);
      meas(16'h00C7, 8'hFF, 4'h8, 8'hFF, 4'h4, 3'b100, 7, 16'h2110, 16'h0007);
      meas(16'h00C6, 8'h00, 4'hD, 8'h00, 4'hE, 3'b010, 4, 16'h1210, 16'h0004);
      meas(16'h0003, 8'h5A, 4'h0, 8'hC3, 4'h0, 3'b001, 2, 16'h5C10, 16'h0002);
      for (d = 0; d < 4; d++) begin
         meas(16'(16'h0002 | (d << 4)), 8'h08, 4'h0, 8'h01, 4'h0, 3'b001, 3 << d,
            16'h8110, 16'h0003);
      end
      meas(16'h0002, 8'h02, 4'h0, 8'h00, 4'h0, 3'b001, 3, 16'h2000, 16'h0000);
      summarize();
   end
endmodule : llm_top_tb_top

`undef CHK
`default_nettype wire
